// *** tb/tb_ttu_translation_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_ttu_translation_unit;
   import ttu_pkg::*;
   logic        clk, rst_n, run, mv_valid, mv_write, mv_supervisor;
   logic        mv_done, mv_priv_fault, acc_valid, acc_rd, acc_rmw;
   logic        acc_resp_valid, acc_transparent, no_cache_output;
   logic        test_valid, test_rd, cache_hit, cache_bus_error;
   logic        cache_wprot, cache_modified, walk_bus_error, walk_limit;
   logic        walk_super_seen, walk_wprot_seen, walk_type_invalid;
   logic        walk_modified, walk_desc_is_table, walk_search_over;
   logic        pend, exp_t, exp_c;
   ttu_sel_t    mv_sel;
   logic [31:0] mv_wdata, mv_rdata, acc_addr, acc_phys_addr, test_addr;
   logic [31:0] exp_p, st_care, r;
   logic [31:0] regs_m [4];
   logic [2:0]  acc_fc, test_level, test_fc, walk_tables;
   logic [1:0]  walk_step_level, h0, h1;
   logic [3:0]  walk_index_width;
   integer      seed, fail_count, total_checks, i, j;
   always #2.5 clk = ~clk;
   ttu_translation_unit i_ttu_translation_unit (
      .clk, .rst_n, .mv_valid, .mv_write, .mv_sel, .mv_wdata, .mv_supervisor,
      .mv_done, .mv_priv_fault, .mv_rdata, .acc_valid, .acc_addr, .acc_fc,
      .acc_rd, .acc_rmw, .acc_resp_valid, .acc_transparent, .acc_phys_addr,
      .no_cache_output, .test_valid, .test_level, .test_addr, .test_fc,
      .test_rd, .cache_hit, .cache_bus_error, .cache_wprot, .cache_modified,
      .walk_bus_error, .walk_limit, .walk_super_seen, .walk_wprot_seen,
      .walk_type_invalid, .walk_modified, .walk_tables, .walk_step_level,
      .walk_desc_is_table, .walk_index_width, .walk_search_over);
   ttu_core_model i_ttu_core_model (
      .clk, .run, .acc_valid, .acc_addr, .acc_fc, .acc_rd, .acc_rmw);
   // ==========
   // Reference model: returns {no_cache, hit} for one window.
   function automatic logic [1:0] win_hit(input logic [31:0] w,
      input logic [31:0] a, input logic [2:0] f, input logic rd, rmw);
      logic h;
      h = w[15] && ((a[31:24] ^ w[31:24]) & ~w[23:16]) == 8'h00
         && ((f ^ w[6:4]) & ~w[2:0]) == 3'h0
         && (w[8] || (!rmw && rd == w[9]));
      return {h & w[10], h};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   always @(posedge clk) begin
      h0 = win_hit(regs_m[1], acc_addr, acc_fc, acc_rd, acc_rmw);
      h1 = win_hit(regs_m[2], acc_addr, acc_fc, acc_rd, acc_rmw);
      pend <= acc_valid & rst_n;
      exp_t <= h0[0] | h1[0];
      exp_c <= h0[1] | h1[1];
      exp_p <= !rst_n ? 32'h0000_0000 : (acc_valid ? acc_addr : exp_p);
   end
   always @(negedge clk) begin
      if (rst_n === 1'h1) begin
         chk({29'h0, acc_resp_valid, acc_transparent, no_cache_output},
             {29'h0, pend, pend & exp_t, pend & exp_c});
         chk(acc_phys_addr, exp_p);
      end
   end
   task automatic reset_dut();
      @(negedge clk);
      rst_n = 1'h0;
      repeat (6) @(negedge clk);
      rst_n = 1'h1;
      regs_m = '{default: 32'h0};
      st_care = 32'hFFFF_FFFF;
   endtask
   task automatic mv(input logic w, input ttu_sel_t s,
                     input logic [31:0] d, input logic sup);
      @(negedge clk);
      mv_valid = 1'h1;
      mv_write = w;
      mv_sel = s;
      mv_wdata = d;
      mv_supervisor = sup;
      @(negedge clk);
      mv_valid = 1'h0;
      chk({30'h0, mv_done, mv_priv_fault}, {30'h0, sup, !sup});
   endtask
   task automatic write_reg(input ttu_sel_t s, input logic [31:0] d);
      mv(1'h1, s, d, 1'h1);
      regs_m[s] = d & (s == TTU_SEL_INDEX_WIDTH ? 32'h0000_FFFF :
         s == TTU_SEL_TEST_STATUS ? {16'h0, TTU_ST_DEFINED} :
         TTU_WIN_WRITABLE);
      st_care = s == TTU_SEL_TEST_STATUS ? 32'hFFFF_FFFF : st_care;
   endtask
   task automatic read_all();
      integer      k;
      logic [31:0] c;
      for (k = 0; k < 4; k++) begin
         c = k == 3 ? st_care : 32'hFFFF_FFFF;
         mv(1'h0, k[1:0], $random(seed), 1'h1);
         chk(mv_rdata & c, regs_m[k] & c);
      end
   endtask
   task automatic walk_query();
      integer     k;
      logic [3:0] w;
      for (k = 0; k < 8; k++) begin
         @(negedge clk);
         walk_step_level = k[1:0];
         walk_desc_is_table = k[2];
         #1;
         w = regs_m[0][15 - 4 * (k % 4) -: 4];
         chk({28'h0, walk_index_width}, {28'h0, w});
         chk({31'h0, walk_search_over}, {31'h0, w == 4'h0 && !k[2]});
      end
   endtask
   task automatic translation_test_op();
      logic [31:0] q;
      logic [1:0]  g0, g1;
      logic        lz, b, l, iv, t;
      @(negedge clk);
      q = $random(seed);
      test_level = q[11] ? 3'h0 : q[2:0];
      {test_fc, test_rd, cache_hit, cache_bus_error, cache_wprot,
       cache_modified} = q[19:12];
      {walk_super_seen, walk_wprot_seen, walk_modified,
       walk_tables} = q[25:20];
      {walk_bus_error, walk_limit, walk_type_invalid} = q[28:26] & q[31:29];
      test_addr = $random(seed) & 32'h8FFF_FFFF;
      test_valid = 1'h1;
      g0 = win_hit(regs_m[1], test_addr, test_fc, test_rd, 1'h0);
      g1 = win_hit(regs_m[2], test_addr, test_fc, test_rd, 1'h0);
      lz = test_level == 3'h0;
      t = lz & (g0[0] | g1[0]);
      b = lz ? cache_hit & cache_bus_error : walk_bus_error;
      l = !lz & walk_limit;
      iv = lz ? !cache_hit | cache_bus_error
              : walk_type_invalid | b | l;
      regs_m[3] = {16'h0, b, l, !lz & walk_super_seen & !test_fc[2],
         1'h0, lz ? cache_wprot : walk_wprot_seen, iv,
         lz ? cache_modified : walk_modified, 2'h0, t, 3'h0,
         lz ? 3'h0 : walk_tables};
      st_care = t ? 32'h0040 : (iv ? 32'hC447 : 32'hEE47);
      @(negedge clk);
      test_valid = 1'h0;
      mv(1'h0, TTU_SEL_TEST_STATUS, $random(seed), 1'h1);
      chk(mv_rdata & st_care, regs_m[3] & st_care);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      end_of_test();
   end
   initial begin
      seed = 89;
      fail_count = 0;
      total_checks = 0;
      clk = 1'h0;
      {rst_n, run, mv_valid, mv_write, mv_supervisor, mv_sel, mv_wdata} = '0;
      {test_valid, test_level, test_addr, test_fc, test_rd, cache_hit,
       cache_bus_error, cache_wprot, cache_modified, walk_bus_error} = '0;
      {walk_limit, walk_super_seen, walk_wprot_seen, walk_type_invalid,
       walk_modified, walk_tables, walk_step_level, walk_desc_is_table} = '0;
      reset_dut();
      read_all();
      for (i = 0; i < 4; i++) begin
         write_reg(i[1:0], $random(seed));
         mv(1'h1, i[1:0], $random(seed), 1'h0);
      end
      read_all();
      for (i = 0; i < 2; i++) begin
         write_reg(TTU_SEL_INDEX_WIDTH,
                   $random(seed) & (i ? 32'hF0F0 : 32'hFFFF));
         walk_query();
      end
      for (j = 0; j < 12; j++) begin
         r = $random(seed) & 32'h8FFF_FFFF;
         write_reg(TTU_SEL_WINDOW_0, j < 8 ? r | 32'h8000 : r & 32'hFFFF_7FFF);
         r = $random(seed) & 32'h8FFF_FFFF;
         write_reg(TTU_SEL_WINDOW_1, j < 8 ? r | 32'h8000 : r & 32'hFFFF_7FFF);
         @(posedge clk) run <= 1'h1;
         repeat (40) @(posedge clk);
         run <= 1'h0;
         repeat (3) @(posedge clk);
         for (i = 0; i < 8; i++) begin
            translation_test_op();
         end
      end
      reset_dut();
      read_all();
      @(posedge clk) run <= 1'h1;
      repeat (20) @(posedge clk);
      run <= 1'h0;
      repeat (3) @(posedge clk);
      end_of_test();
   end
endmodule
bind ttu_translation_unit ttu_translation_unit_sva i_ttu_translation_unit_sva (
   .clk, .rst_n, .mv_valid, .mv_write, .mv_sel, .mv_supervisor, .mv_done,
   .mv_priv_fault, .acc_valid, .acc_addr, .acc_resp_valid, .acc_transparent,
   .acc_phys_addr, .no_cache_output, .walk_index_width, .walk_desc_is_table,
   .walk_search_over);
`default_nettype wire

// *** tb/ttu_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ttu_core_model (
   input  wire logic   clk,
   input  wire logic   run,
   output logic        acc_valid,
   output logic [31:0] acc_addr,
   output logic [2:0]  acc_fc,
   output logic        acc_rd,
   output logic        acc_rmw
);
   integer      seed;
   logic [31:0] q;
   initial begin
      seed = 89;
      {acc_valid, acc_addr, acc_fc, acc_rd, acc_rmw} = '0;
   end
   // Attribute lines change every cycle, so an idle bus never looks stale.
   always @(negedge clk) begin
      q = $random(seed);
      acc_valid <= run & (q[0] | q[1]);
      acc_fc <= q[4:2];
      acc_rd <= q[5];
      acc_rmw <= q[6] & q[7];
      acc_addr <= $random(seed) & 32'h8FFF_FFFF;
   end
endmodule
`default_nettype wire

// *** tb/ttu_translation_unit_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module ttu_translation_unit_sva
   import ttu_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              mv_valid,
   input wire logic              mv_write,
   input wire ttu_pkg::ttu_sel_t mv_sel,
   input wire logic              mv_supervisor,
   input wire logic              mv_done,
   input wire logic              mv_priv_fault,
   input wire logic              acc_valid,
   input wire logic [31:0]       acc_addr,
   input wire logic              acc_resp_valid,
   input wire logic              acc_transparent,
   input wire logic [31:0]       acc_phys_addr,
   input wire logic              no_cache_output,
   input wire logic [3:0]        walk_index_width,
   input wire logic              walk_desc_is_table,
   input wire logic              walk_search_over
);
   // ==========
   // Remembers whether a window was loaded since the last reset.
   logic win_wr_q;
   logic win_wr_d;
   always_comb begin
      win_wr_d = win_wr_q | (mv_valid & mv_write & mv_supervisor &
         (mv_sel == TTU_SEL_WINDOW_0 | mv_sel == TTU_SEL_WINDOW_1));
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_wr_q <= 1'h0;
      end else begin
         win_wr_q <= win_wr_d;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_move_req;
      mv_valid && mv_supervisor;
   endsequence
   sequence s_move_ok;
      ##1 (mv_done && !mv_priv_fault);
   endsequence
   chk_move_done: assert property (s_move_req |-> s_move_ok)
      else $error("move not answered");
   chk_move_refused: assert property (
      mv_valid && !mv_supervisor |=> mv_priv_fault && !mv_done)
      else $error("user move not refused");
   chk_move_quiet: assert property (
      !mv_valid |=> !mv_done && !mv_priv_fault)
      else $error("move answer without request");
   chk_resp_timing: assert property (acc_valid |=> acc_resp_valid)
      else $error("access not answered");
   chk_resp_quiet: assert property (
      !acc_valid |=> !acc_resp_valid && !acc_transparent && !no_cache_output)
      else $error("response without access");
   chk_phys_same: assert property (
      acc_valid |=> acc_phys_addr == $past(acc_addr))
      else $error("physical address changed");
   chk_nocache_hit: assert property (
      no_cache_output |-> acc_transparent)
      else $error("no-cache without window match");
   chk_reset_closed: assert property (!win_wr_q |=> !acc_transparent)
      else $error("window open after reset");
   chk_search_end: assert property (
      walk_search_over == (walk_index_width == 4'h0 && !walk_desc_is_table))
      else $error("search end wrong");
endmodule
`default_nettype wire

// *** verilog/ttu_pkg.sv ***
package ttu_pkg;

   // =====================================================
   // Register selects for the privileged register move
   // =====================================================
   typedef logic [1:0] ttu_sel_t;
   localparam ttu_sel_t TTU_SEL_INDEX_WIDTH = 2'h0;
   localparam ttu_sel_t TTU_SEL_WINDOW_0    = 2'h1;
   localparam ttu_sel_t TTU_SEL_WINDOW_1    = 2'h2;
   localparam ttu_sel_t TTU_SEL_TEST_STATUS = 2'h3;

   // =====================================================
   // Transparent window field layout
   // =====================================================
   localparam int TTU_WIN_BASE_LSB   = 24;
   localparam int TTU_WIN_MASK_LSB   = 16;
   localparam int TTU_WIN_ENABLE     = 15;
   localparam int TTU_WIN_NO_CACHE   = 10;
   localparam int TTU_WIN_DIRECTION  = 9;
   localparam int TTU_WIN_DIR_IGNORE = 8;
   localparam int TTU_WIN_FC_VAL_LSB = 4;
   localparam int TTU_WIN_FC_IGN_LSB = 0;
   localparam logic [31:0] TTU_WIN_RESET     = 32'h0000_0000;
   localparam logic [31:0] TTU_WIN_WRITABLE  = 32'hFFFF_8777;

   // =====================================================
   // Index width register layout
   // =====================================================
   localparam int TTU_IDX_LEVEL_ONE_LSB   = 12;
   localparam int TTU_IDX_LEVEL_TWO_LSB   = 8;
   localparam int TTU_IDX_LEVEL_THREE_LSB = 4;
   localparam int TTU_IDX_LEVEL_FOUR_LSB  = 0;
   localparam logic [15:0] TTU_IDX_RESET  = 16'h0000;

   // =====================================================
   // Translation test status layout
   // =====================================================
   localparam int TTU_ST_BUS_ERROR = 15;
   localparam int TTU_ST_LIMIT     = 14;
   localparam int TTU_ST_SUPER     = 13;
   localparam int TTU_ST_WPROT     = 11;
   localparam int TTU_ST_INVALID   = 10;
   localparam int TTU_ST_MODIFIED  = 9;
   localparam int TTU_ST_TRANSP    = 6;
   localparam int TTU_ST_LEVELS_LSB = 0;
   localparam logic [15:0] TTU_ST_RESET  = 16'h0000;
   localparam logic [15:0] TTU_ST_DEFINED = 16'hEE47;

   // Equality of two fields with ignore bits.
   function automatic logic ttu_masked_eq(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic [7:0] ign);
      ttu_masked_eq = ((a ^ b) & ~ign) == 8'h00;
   endfunction

endpackage

// *** verilog/ttu_status_compose.sv ***
`timescale 1ns/100ps
`default_nettype none
module ttu_status_compose
   import ttu_pkg::*;
(
   input  wire logic [2:0]  level,
   input  wire logic        fc_high,
   input  wire logic        window_hit,
   input  wire logic        cache_hit,
   input  wire logic        cache_bus_error,
   input  wire logic        cache_wprot,
   input  wire logic        cache_modified,
   input  wire logic        walk_bus_error,
   input  wire logic        walk_limit,
   input  wire logic        walk_super_seen,
   input  wire logic        walk_wprot_seen,
   input  wire logic        walk_type_invalid,
   input  wire logic        walk_modified,
   input  wire logic [2:0]  walk_tables,
   output logic [15:0]      status
);
   logic bus_err;
   logic limit;
   logic super_v;
   logic wprot;
   logic invalid;
   logic modified;

   always_comb begin
      status = TTU_ST_RESET;
      if (level == 3'h0) begin
         bus_err  = cache_hit & cache_bus_error;
         limit    = 1'b0;
         super_v  = 1'b0;
         invalid  = ~cache_hit | cache_bus_error;
         wprot    = cache_wprot;
         modified = cache_modified;
      end else begin
         bus_err  = walk_bus_error;
         limit    = walk_limit;
         super_v  = walk_super_seen & ~fc_high;
         invalid  = walk_type_invalid | walk_bus_error | walk_limit;
         wprot    = walk_wprot_seen;
         modified = walk_modified;
      end
      if (level == 3'h0 && window_hit) begin
         status[TTU_ST_TRANSP] = 1'b1;
      end else begin
         status[TTU_ST_BUS_ERROR] = bus_err;
         status[TTU_ST_LIMIT]     = limit;
         status[TTU_ST_INVALID]   = invalid;
         status[TTU_ST_SUPER]     = super_v & ~invalid;
         status[TTU_ST_WPROT]     = wprot & ~invalid;
         status[TTU_ST_MODIFIED]  = modified & ~invalid;
         if (level != 3'h0) begin
            status[TTU_ST_LEVELS_LSB +: 3] = walk_tables;
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/ttu_translation_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module ttu_translation_unit
   import ttu_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Privileged register move.
   input  wire logic               mv_valid,
   input  wire logic               mv_write,
   input  wire ttu_pkg::ttu_sel_t  mv_sel,
   input  wire logic [31:0]        mv_wdata,
   input  wire logic               mv_supervisor,
   output logic                    mv_done,
   output logic                    mv_priv_fault,
   output logic [31:0]             mv_rdata,
   // Logical access from the core.
   input  wire logic               acc_valid,
   input  wire logic [31:0]        acc_addr,
   input  wire logic [2:0]         acc_fc,
   input  wire logic               acc_rd,
   input  wire logic               acc_rmw,
   output logic                    acc_resp_valid,
   output logic                    acc_transparent,
   output logic [31:0]             acc_phys_addr,
   output logic                    no_cache_output,
   // Translation test operation.
   input  wire logic               test_valid,
   input  wire logic [2:0]         test_level,
   input  wire logic [31:0]        test_addr,
   input  wire logic [2:0]         test_fc,
   input  wire logic               test_rd,
   input  wire logic               cache_hit,
   input  wire logic               cache_bus_error,
   input  wire logic               cache_wprot,
   input  wire logic               cache_modified,
   input  wire logic               walk_bus_error,
   input  wire logic               walk_limit,
   input  wire logic               walk_super_seen,
   input  wire logic               walk_wprot_seen,
   input  wire logic               walk_type_invalid,
   input  wire logic               walk_modified,
   input  wire logic [2:0]         walk_tables,
   // Table walk step query.
   input  wire logic [1:0]         walk_step_level,
   input  wire logic               walk_desc_is_table,
   output logic [3:0]              walk_index_width,
   output logic                    walk_search_over
);
   import ttu_pkg::*;

   // =====================================================
   // Register state
   // =====================================================
   logic [31:0] win0_q;
   logic [31:0] win0_d;
   logic [31:0] win1_q;
   logic [31:0] win1_d;
   logic [15:0] idx_q;
   logic [15:0] idx_d;
   logic [15:0] status_q;
   logic [15:0] status_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        done_q;
   logic        done_d;
   logic        fault_q;
   logic        fault_d;
   logic        mv_ok;
   logic [3:0]  mv_hot;
   logic [31:0] mv_wval;
   logic [15:0] test_status;

   // =====================================================
   // Window matching for accesses and tests
   // =====================================================
   logic acc_hit0;
   logic acc_hit1;
   logic acc_nc0;
   logic acc_nc1;
   logic tst_hit0;
   logic tst_hit1;

   ttu_window_match u_acc_win0 (
      .window   (win0_q),
      .addr_hi  (acc_addr[31:24]),
      .fc       (acc_fc),
      .rd       (acc_rd),
      .rmw      (acc_rmw),
      .hit      (acc_hit0),
      .no_cache (acc_nc0)
   );

   ttu_window_match u_acc_win1 (
      .window   (win1_q),
      .addr_hi  (acc_addr[31:24]),
      .fc       (acc_fc),
      .rd       (acc_rd),
      .rmw      (acc_rmw),
      .hit      (acc_hit1),
      .no_cache (acc_nc1)
   );

   ttu_window_match u_tst_win0 (
      .window   (win0_q),
      .addr_hi  (test_addr[31:24]),
      .fc       (test_fc),
      .rd       (test_rd),
      .rmw      (1'b0),
      .hit      (tst_hit0),
      .no_cache ()
   );

   ttu_window_match u_tst_win1 (
      .window   (win1_q),
      .addr_hi  (test_addr[31:24]),
      .fc       (test_fc),
      .rd       (test_rd),
      .rmw      (1'b0),
      .hit      (tst_hit1),
      .no_cache ()
   );

   ttu_status_compose u_status (
      .level             (test_level),
      .fc_high           (test_fc[2]),
      .window_hit        (tst_hit0 | tst_hit1),
      .cache_hit         (cache_hit),
      .cache_bus_error   (cache_bus_error),
      .cache_wprot       (cache_wprot),
      .cache_modified    (cache_modified),
      .walk_bus_error    (walk_bus_error),
      .walk_limit        (walk_limit),
      .walk_super_seen   (walk_super_seen),
      .walk_wprot_seen   (walk_wprot_seen),
      .walk_type_invalid (walk_type_invalid),
      .walk_modified     (walk_modified),
      .walk_tables       (walk_tables),
      .status            (test_status)
   );

   // =====================================================
   // Register move decoding
   // =====================================================
   // One enable per register, so reads and writes share one decoder.
   function automatic logic [3:0] move_onehot(input ttu_sel_t sel);
      logic [3:0] hot;
      hot = 4'h0;
      if (sel == TTU_SEL_INDEX_WIDTH) begin
         hot[0] = 1'b1;
      end else if (sel == TTU_SEL_WINDOW_0) begin
         hot[1] = 1'b1;
      end else if (sel == TTU_SEL_WINDOW_1) begin
         hot[2] = 1'b1;
      end else begin
         hot[3] = 1'b1;
      end
      return hot;
   endfunction

   // Bits that a move may load; the others always read back as zero.
   function automatic logic [31:0] move_wmask(input logic [3:0] hot);
      if (hot[0]) begin
         move_wmask = 32'h0000_FFFF;
      end else if (hot[3]) begin
         move_wmask = {16'h0000, TTU_ST_DEFINED};
      end else begin
         move_wmask = TTU_WIN_WRITABLE;
      end
   endfunction

   // Read value of the picked register; short ones sit in bits 15:0.
   function automatic logic [31:0] move_rvalue(input logic [3:0]  hot,
                                               input logic [15:0] idx,
                                               input logic [31:0] w0,
                                               input logic [31:0] w1,
                                               input logic [15:0] st);
      if (hot[0]) begin
         move_rvalue = {16'h0000, idx};
      end else if (hot[1]) begin
         move_rvalue = w0;
      end else if (hot[2]) begin
         move_rvalue = w1;
      end else begin
         move_rvalue = {16'h0000, st};
      end
   endfunction

   // =====================================================
   // Register move and status update
   // =====================================================
   always_comb begin
      win0_d   = win0_q;
      win1_d   = win1_q;
      idx_d    = idx_q;
      status_d = status_q;
      rdata_d  = rdata_q;
      mv_hot   = move_onehot(mv_sel);
      mv_wval  = mv_wdata & move_wmask(mv_hot);
      mv_ok    = mv_valid & mv_supervisor;
      done_d   = mv_ok;
      fault_d  = mv_valid & ~mv_supervisor;
      // A status write by a move in the same cycle wins over a test.
      if (test_valid) begin
         status_d = test_status;
      end
      if (mv_ok && mv_write) begin
         if (mv_hot[0]) begin
            idx_d = mv_wval[15:0];
         end else if (mv_hot[1]) begin
            win0_d = mv_wval;
         end else if (mv_hot[2]) begin
            win1_d = mv_wval;
         end else begin
            status_d = mv_wval[15:0];
         end
      end else if (mv_ok) begin
         rdata_d = move_rvalue(mv_hot, idx_q, win0_q, win1_q, status_q);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win0_q   <= TTU_WIN_RESET;
         win1_q   <= TTU_WIN_RESET;
         idx_q    <= TTU_IDX_RESET;
         status_q <= TTU_ST_RESET;
         rdata_q  <= 32'h0000_0000;
         done_q   <= 1'b0;
         fault_q  <= 1'b0;
      end else begin
         win0_q   <= win0_d;
         win1_q   <= win1_d;
         idx_q    <= idx_d;
         status_q <= status_d;
         rdata_q  <= rdata_d;
         done_q   <= done_d;
         fault_q  <= fault_d;
      end
   end

   assign mv_done       = done_q;
   assign mv_priv_fault = fault_q;
   assign mv_rdata      = rdata_q;

   // =====================================================
   // Access response, one cycle after the request
   // =====================================================
   logic        resp_valid_q;
   logic        resp_valid_d;
   logic        transp_q;
   logic        transp_d;
   logic        nocache_q;
   logic        nocache_d;
   logic [31:0] phys_q;
   logic [31:0] phys_d;

   // Window hits do not look at any translation enable or disable.
   always_comb begin
      resp_valid_d = acc_valid;
      transp_d     = acc_valid & (acc_hit0 | acc_hit1);
      nocache_d    = acc_valid & (acc_nc0 | acc_nc1);
      phys_d       = phys_q;
      if (acc_valid) begin
         phys_d = acc_addr;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resp_valid_q <= 1'b0;
         transp_q     <= 1'b0;
         nocache_q    <= 1'b0;
         phys_q       <= 32'h0000_0000;
      end else begin
         resp_valid_q <= resp_valid_d;
         transp_q     <= transp_d;
         nocache_q    <= nocache_d;
         phys_q       <= phys_d;
      end
   end

   assign acc_resp_valid  = resp_valid_q;
   assign acc_transparent = transp_q;
   assign acc_phys_addr   = phys_q;
   assign no_cache_output = nocache_q;

   // =====================================================
   // Table walk stop decision
   // =====================================================
   always_comb begin
      case (walk_step_level)
         2'h0: walk_index_width = idx_q[TTU_IDX_LEVEL_ONE_LSB +: 4];
         2'h1: walk_index_width = idx_q[TTU_IDX_LEVEL_TWO_LSB +: 4];
         2'h2: walk_index_width = idx_q[TTU_IDX_LEVEL_THREE_LSB +: 4];
         default: walk_index_width = idx_q[TTU_IDX_LEVEL_FOUR_LSB +: 4];
      endcase
      walk_search_over = (walk_index_width == 4'h0) &
                         ~walk_desc_is_table;
   end

endmodule
`default_nettype wire

// *** verilog/ttu_window_match.sv ***
`timescale 1ns/100ps
`default_nettype none
module ttu_window_match
   import ttu_pkg::*;
(
   input  wire logic [31:0] window,
   input  wire logic [7:0]  addr_hi,
   input  wire logic [2:0]  fc,
   input  wire logic        rd,
   input  wire logic        rmw,
   output logic             hit,
   output logic             no_cache
);
   logic addr_ok;
   logic fc_ok;
   logic dir_ok;

   always_comb begin
      addr_ok = ttu_masked_eq(addr_hi,
                              window[TTU_WIN_BASE_LSB +: 8],
                              window[TTU_WIN_MASK_LSB +: 8]);
      fc_ok = ttu_masked_eq({5'h00, fc},
                            {5'h00, window[TTU_WIN_FC_VAL_LSB +: 3]},
                            {5'h00, window[TTU_WIN_FC_IGN_LSB +: 3]});
      if (window[TTU_WIN_DIR_IGNORE]) begin
         dir_ok = 1'b1;
      end else if (rmw) begin
         dir_ok = 1'b0;
      end else begin
         dir_ok = (window[TTU_WIN_DIRECTION] == rd);
      end
      hit = window[TTU_WIN_ENABLE] & addr_ok & fc_ok & dir_ok;
      no_cache = hit & window[TTU_WIN_NO_CACHE];
   end
endmodule
`default_nettype wire
